// >>> inc/osc_cfg.svh
// register offsets, field positions, reset values and timing counts of the oscillator control
`ifndef OSC_CFG_SVH
`define OSC_CFG_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OSC_OFF_CONTROL 16'h1200
`define OSC_OFF_UNLOCK 16'h1210
`define OSC_OFF_NMI 16'h1220
`define OSC_OFF_SLEW 16'h1300
`define OSC_OFF_READY 16'h1390
// ----------------------------------------
// control field positions
// ----------------------------------------
`define OSC_DIV_HI 26
`define OSC_DIV_LO 24
`define OSC_DREAM_BIT 23
`define OSC_SLP2_BIT 21
`define OSC_CUR_HI 14
`define OSC_CUR_LO 12
`define OSC_NEW_HI 10
`define OSC_NEW_LO 8
`define OSC_LOCK_BIT 7
`define OSC_SLEEP_ON_WAIT_BIT 4
`define OSC_CF_BIT 3
`define OSC_SEC_BIT 1
`define OSC_SW_BIT 0
`define OSC_NMI_CF_BIT 17
// ----------------------------------------
// reset values and keys
// ----------------------------------------
`define OSC_SLEW_RESET 32'h0000_0000
`define OSC_KEY1 32'haa99_6655
`define OSC_KEY2 32'h5566_99aa
`define OSC_SLEW_MASK 32'h000f_0706
// cycles the current source is held while a new one comes ready
`define OSC_SETTLE_CYCLES 16
`endif

// >>> inc/osc_pkg.sv
// types shared by the oscillator control files
package osc_pkg;
  typedef logic [2:0] osc_src_t;
  // clock source codes, 011 and 111 reserved
  localparam osc_src_t OSC_FRC = 3'h0;
  localparam osc_src_t OSC_PLL = 3'h1;
  localparam osc_src_t OSC_PRI = 3'h2;
  localparam osc_src_t OSC_SEC = 3'h4;
  localparam osc_src_t OSC_LOW_POWER_INTERNAL_RC = 3'h5;
  localparam osc_src_t OSC_BACKUP_INTERNAL_RC = 3'h6;
  typedef enum logic [1:0] {OSC_UNLK_IDLE, OSC_UNLK_ONE, OSC_UNLK_OPEN} osc_unlk_e;
  typedef enum logic [1:0] {OSC_SW_IDLE, OSC_SW_WAIT} osc_sw_e;
endpackage

// >>> inc/osc_sw_if.sv
// switch request and completion between register file and switcher
`timescale 1ns/10ps
`default_nettype none
interface osc_sw_if;
  logic start;
  logic [2:0] target;
  logic done;
  logic [2:0] current;
  modport ctl (output start, output target, input done, input current);
  modport sw (input start, input target, output done, output current);
endinterface
`default_nettype wire

// >>> core/osc_switcher.sv
// clock source switcher: waits for readiness, then moves the current source
`timescale 1ns/10ps
`default_nettype none
`include "osc_cfg.svh"
module osc_switcher #(
  parameter int SETTLE = `OSC_SETTLE_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [2:0] boot_src_in,
  input wire logic [5:0] ready_in,
  osc_sw_if.sw sw
);
  import osc_pkg::*;
  osc_sw_e state_ff;
  osc_sw_e nxt_state;
  logic [2:0] cur_ff;
  logic [2:0] tgt_ff;
  logic [7:0] cnt_ff;
  logic tgt_ready;
  logic settled;
  logic done_ff;
  // ----------------------------------------
  // readiness of the target source
  // ----------------------------------------
  // ready order: frc, pll, pri, sec, low_power_internal_rc, backup_internal_rc
  assign tgt_ready = (tgt_ff == OSC_FRC) ? ready_in[0] :
                     (tgt_ff == OSC_PLL) ? ready_in[1] :
                     (tgt_ff == OSC_PRI) ? ready_in[2] :
                     (tgt_ff == OSC_SEC) ? ready_in[3] :
                     (tgt_ff == OSC_LOW_POWER_INTERNAL_RC) ? ready_in[4] : ready_in[5];
  assign settled = tgt_ready && (cnt_ff >= 8'(SETTLE));
  // next state, old source kept until settled
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      OSC_SW_IDLE: if (sw.start) nxt_state = OSC_SW_WAIT;
      OSC_SW_WAIT: if (settled) nxt_state = OSC_SW_IDLE;
    endcase
  end
  // sequencer registers; cur_ff boots at the source the top hands in
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_ff <= OSC_SW_IDLE;
      cur_ff <= boot_src_in;
      tgt_ff <= OSC_FRC;
      cnt_ff <= 8'h00;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      done_ff <= (state_ff == OSC_SW_WAIT) && settled;
      if (state_ff == OSC_SW_IDLE && sw.start) begin
        tgt_ff <= sw.target;
        cnt_ff <= 8'h00;
      end else if (cnt_ff != 8'hff) begin
        cnt_ff <= cnt_ff + 8'h01;
      end
      if (state_ff == OSC_SW_WAIT && settled) cur_ff <= tgt_ff;
    end
  end
  assign sw.done = done_ff;
  assign sw.current = cur_ff;
endmodule
`default_nettype wire

// >>> core/osc_ctrl.sv
// oscillator control register block with wishbone slave
`timescale 1ns/10ps
`default_nettype none
`include "osc_cfg.svh"
module osc_ctrl #(
  parameter int SETTLE = `OSC_SETTLE_CYCLES
) (
  input wire logic REF_CLK_IN,
  input wire logic RESET_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [15:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  input wire logic [2:0] INITIAL_SOURCE_FUSES_IN,
  input wire logic TWO_SPEED_FUSE_IN,
  input wire logic [1:0] SWITCH_MONITOR_FUSES_IN,
  input wire logic FAIL_SAFE_MONITOR_IN,
  input wire logic WAKE_IN,
  input wire logic WAIT_IN,
  input wire logic [5:0] SOURCE_READY_IN,
  output logic [2:0] SYSTEM_CLOCK_SOURCE_OUT,
  output logic [2:0] FAST_RC_DIVIDER_OUT,
  output logic DREAM_MODE_OUT,
  output logic SECONDARY_OSC_ENABLE_OUT,
  output logic SLEEP_OUT,
  output logic IDLE_OUT,
  output logic NMI_OUT
);
  import osc_pkg::*;
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [8:0] pin_s1_ff;
  logic [8:0] pin_s2_ff;
  logic fail_s;
  logic wake_s;
  logic wait_s;
  logic [5:0] ready_s;
  // monitor, wake, wait and ready come from other clock domains
  always_ff @(posedge REF_CLK_IN) begin
    pin_s1_ff <= {FAIL_SAFE_MONITOR_IN, WAKE_IN, WAIT_IN, SOURCE_READY_IN};
    pin_s2_ff <= pin_s1_ff;
  end
  assign fail_s = pin_s2_ff[8];
  assign wake_s = pin_s2_ff[7];
  assign wait_s = pin_s2_ff[6];
  assign ready_s = pin_s2_ff[5:0];
  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic req;
  logic wr;
  logic ack_ff;
  logic hit_ctl;
  logic hit_unlk;
  logic hit_nmi;
  logic hit_slew;
  logic hit_rdy;
  logic [31:0] wmask;
  logic [31:0] rd_mux;
  logic [31:0] rd_ff;
  // one wait state: ack in the cycle after the strobe, dropped after one cycle
  assign req = WB_CYC_IN && WB_STB_IN && !ack_ff;
  assign wr = req && WB_WE_IN;
  assign hit_ctl = (WB_ADR_IN == `OSC_OFF_CONTROL);
  assign hit_unlk = (WB_ADR_IN == `OSC_OFF_UNLOCK);
  assign hit_nmi = (WB_ADR_IN == `OSC_OFF_NMI);
  assign hit_slew = (WB_ADR_IN == `OSC_OFF_SLEW);
  assign hit_rdy = (WB_ADR_IN == `OSC_OFF_READY);
  assign wmask = {{8{WB_SEL_IN[3]}}, {8{WB_SEL_IN[2]}}, {8{WB_SEL_IN[1]}}, {8{WB_SEL_IN[0]}}};
  // ----------------------------------------
  // unlock sequence
  // ----------------------------------------
  osc_unlk_e unlk_ff;
  osc_unlk_e nxt_unlk;
  logic open_now;
  logic ctl_wr;
  assign open_now = (unlk_ff == OSC_UNLK_OPEN);
  // a control write without an open unlock is ignored
  assign ctl_wr = wr && hit_ctl && open_now;
  // two key words in order open one write; a control write or a wrong unlock word relocks
  always_comb begin
    nxt_unlk = unlk_ff;
    if (wr && hit_unlk) begin
      if (WB_DAT_IN == `OSC_KEY1) nxt_unlk = OSC_UNLK_ONE;
      else if (unlk_ff == OSC_UNLK_ONE && WB_DAT_IN == `OSC_KEY2) nxt_unlk = OSC_UNLK_OPEN;
      else nxt_unlk = OSC_UNLK_IDLE;
    end else if (wr && hit_ctl) begin
      nxt_unlk = OSC_UNLK_IDLE;
    end
  end
  // ----------------------------------------
  // lock
  // ----------------------------------------
  logic lock_ff;
  logic locked;
  logic sel_wr;
  // lock binds only while switching is disabled by fuse
  assign locked = lock_ff && SWITCH_MONITOR_FUSES_IN[1];
  // frozen fields refuse writes until reset
  assign sel_wr = ctl_wr && !locked;
  // ----------------------------------------
  // control fields
  // ----------------------------------------
  logic [2:0] div_ff;
  logic dream_ff;
  logic slp2_ff;
  logic [2:0] new_ff;
  logic sleep_on_wait_ff;
  logic cf_ff;
  logic sec_ff;
  logic swreq_ff;
  logic nmi_cf_ff;
  logic fail_d_ff;
  logic boot_ff;
  logic sleep_ff;
  logic wake2_ff;
  logic fsm_on;
  logic fail_rise;
  logic cf_sw_set;
  logic sw_start;
  logic [2:0] sw_target;
  logic [31:0] slew_ff;
  osc_sw_if swif ();
  assign fsm_on = (SWITCH_MONITOR_FUSES_IN == 2'b11);
  assign fail_rise = fail_s && !fail_d_ff;
  assign cf_sw_set = ctl_wr && WB_SEL_IN[0] && WB_DAT_IN[`OSC_CF_BIT] && !cf_ff;
  // with full monitoring, a monitor failure or software set forces a switch to frc
  assign sw_start = (fsm_on && (fail_rise || cf_sw_set)) ||
                    (swreq_ff && !boot_ff && !swif.done) ||
                    (wake_s && sleep_ff && slp2_ff);
  assign sw_target = (fsm_on && (fail_rise || cf_sw_set)) ? OSC_FRC : new_ff;
  assign swif.start = sw_start;
  assign swif.target = sw_target;
  // fuse-fed fields take their value at reset from the fuse pins
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      div_ff <= 3'h0; // divide by one
      dream_ff <= 1'b0;
      slp2_ff <= 1'b0;
      new_ff <= INITIAL_SOURCE_FUSES_IN;
      lock_ff <= 1'b0;
      sleep_on_wait_ff <= 1'b0;
      sec_ff <= 1'b0;
      swreq_ff <= TWO_SPEED_FUSE_IN;
      boot_ff <= 1'b1;
      wake2_ff <= 1'b0;
      slew_ff <= `OSC_SLEW_RESET;
    end else begin
      boot_ff <= 1'b0;
      if (wake_s && sleep_ff && slp2_ff) wake2_ff <= 1'b1;
      else if (swif.done) wake2_ff <= 1'b0;
      if (sel_wr && WB_SEL_IN[3]) div_ff <= WB_DAT_IN[`OSC_DIV_HI:`OSC_DIV_LO];
      if (ctl_wr && WB_SEL_IN[2]) dream_ff <= WB_DAT_IN[`OSC_DREAM_BIT];
      if (sel_wr && WB_SEL_IN[2]) slp2_ff <= WB_DAT_IN[`OSC_SLP2_BIT];
      if (sel_wr && WB_SEL_IN[1]) new_ff <= WB_DAT_IN[`OSC_NEW_HI:`OSC_NEW_LO];
      if (sel_wr && WB_SEL_IN[0]) begin
        lock_ff <= lock_ff | WB_DAT_IN[`OSC_LOCK_BIT]; // only reset clears it
        sleep_on_wait_ff <= WB_DAT_IN[`OSC_SLEEP_ON_WAIT_BIT];
        sec_ff <= WB_DAT_IN[`OSC_SEC_BIT];
      end
      // completion clears the request; a new write in the same cycle wins
      if (sel_wr && WB_SEL_IN[0] && WB_DAT_IN[`OSC_SW_BIT]) swreq_ff <= 1'b1;
      else if (swif.done) swreq_ff <= 1'b0;
      if (wr && hit_slew && !locked) slew_ff <= (WB_DAT_IN & wmask & `OSC_SLEW_MASK);
    end
  end
  // ----------------------------------------
  // clock fail flags and nmi
  // ----------------------------------------
  logic nmi_wr;
  assign nmi_wr = wr && hit_nmi && WB_SEL_IN[2];
  // set beats clear on both flags
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      cf_ff <= 1'b0;
      nmi_cf_ff <= 1'b0;
      fail_d_ff <= 1'b0;
    end else begin
      fail_d_ff <= fail_s;
      if (fail_rise) cf_ff <= 1'b1;
      else if (ctl_wr && WB_SEL_IN[0]) cf_ff <= WB_DAT_IN[`OSC_CF_BIT];
      if (fail_rise && fsm_on) nmi_cf_ff <= 1'b1;
      else if (nmi_wr) nmi_cf_ff <= WB_DAT_IN[`OSC_NMI_CF_BIT];
      else if (swif.done && swreq_ff && cf_ff) nmi_cf_ff <= 1'b0;
    end
  end
  // the nmi copy raises the nmi, the control flag only with full monitoring; only the control flag moves the clock
  assign NMI_OUT = (cf_ff && fsm_on) || nmi_cf_ff;
  // ----------------------------------------
  // sleep, idle and two-speed wake
  // ----------------------------------------
  // wait picks sleep or idle; wake leaves both
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      sleep_ff <= 1'b0;
      IDLE_OUT <= 1'b0;
    end else if (wake_s) begin
      sleep_ff <= 1'b0;
      IDLE_OUT <= 1'b0;
    end else if (wait_s) begin
      sleep_ff <= sleep_on_wait_ff;
      IDLE_OUT <= !sleep_on_wait_ff;
    end
  end
  assign SLEEP_OUT = sleep_ff;
  // ----------------------------------------
  // switcher
  // ----------------------------------------
  logic [2:0] boot_src;
  // two-speed boots on frc, then switches to the fused source, lock or not
  // wake with two-speed set runs frc until the switcher is done
  assign boot_src = TWO_SPEED_FUSE_IN ? OSC_FRC : INITIAL_SOURCE_FUSES_IN;
  osc_switcher #(.SETTLE(SETTLE)) u_sw (
    .clk_in(REF_CLK_IN),
    .rst_in(RESET_IN),
    .boot_src_in(boot_src),
    .ready_in(ready_s),
    .sw(swif)
  );
  assign SYSTEM_CLOCK_SOURCE_OUT = (wake2_ff || (sleep_ff && slp2_ff)) ? OSC_FRC : swif.current;
  assign FAST_RC_DIVIDER_OUT = div_ff;
  assign DREAM_MODE_OUT = dream_ff;
  assign SECONDARY_OSC_ENABLE_OUT = sec_ff;
  // ----------------------------------------
  // read mux and ack
  // ----------------------------------------
  logic [31:0] ctl_word;
  assign ctl_word = {5'h00, div_ff, dream_ff, 1'b0, slp2_ff, 6'h00,
                     SYSTEM_CLOCK_SOURCE_OUT, 1'b0, new_ff, lock_ff, 2'b00, sleep_on_wait_ff,
                     cf_ff, 1'b0, sec_ff, swreq_ff};
  assign rd_mux = hit_ctl ? ctl_word :
                  hit_nmi ? {14'h0, nmi_cf_ff, 17'h0} :
                  hit_slew ? slew_ff :
                  hit_rdy ? {24'h000000, ready_s[1], 1'b0, ready_s[4], ready_s[3],
                             1'b0, ready_s[2], 1'b0, ready_s[0]} : 32'h0000_0000;
  // unmapped addresses ack with zero data; unlock state steps with the bus
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      ack_ff <= 1'b0;
      rd_ff <= 32'h0000_0000;
      unlk_ff <= OSC_UNLK_IDLE;
    end else begin
      ack_ff <= req;
      unlk_ff <= nxt_unlk;
      if (req && !WB_WE_IN) rd_ff <= rd_mux;
    end
  end
  assign WB_ACK_OUT = ack_ff;
  assign WB_DAT_OUT = rd_ff;
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_key_pair;
    (wr && hit_unlk && WB_DAT_IN == `OSC_KEY1) ##1 (!wr)[*2] ##1
    (wr && hit_unlk && WB_DAT_IN == `OSC_KEY2);
  endsequence
  a_ack_one_cycle: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    req |=> ack_ff ##1 !ack_ff) else $error("ack not a single cycle");
  a_write_locked_out: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    (wr && hit_ctl && !open_now && WB_SEL_IN[1]) |=> $stable(new_ff))
    else $error("control written without unlock");
  a_lock_freezes_src: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    locked |=> $stable(new_ff) && $stable(div_ff)) else $error("locked field changed");
  a_lock_sticky: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    lock_ff |=> lock_ff) else $error("lock released without reset");
  a_unlock_opens: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    s_key_pair |=> open_now) else $error("unlock keys did not open");
  a_fail_sets_flag: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    fail_rise |=> cf_ff) else $error("clock fail not flagged");
  a_fail_to_frc: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    (fail_rise && fsm_on && swif.current != OSC_FRC) |-> ##[1:300] (swif.current == OSC_FRC))
    else $error("fail did not switch to frc");
  a_nmi_from_copy: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    nmi_cf_ff |-> NMI_OUT) else $error("nmi copy did not raise nmi");
  a_sleep_choice: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    (wait_s && !wake_s) |=> (sleep_ff == $past(sleep_on_wait_ff)) && (IDLE_OUT != sleep_ff))
    else $error("wait mode choice wrong");
endmodule
`default_nettype wire

// >>> verification/osc_ctrl_test.sv
// self-checking bench for the oscillator control register block
`timescale 1ns/10ps
`default_nettype none
`include "osc_cfg.svh"
// ----------------------------------------
// compare and bounded wait helpers
// ----------------------------------------
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
`define WAIT_FOR(c) begin wn = 0; while (!(c) && wn < 300) begin @(posedge clk); wn++; end \
  if (!(c)) begin fails++; $display("unexpected wait timeout"); end_sim(); end end
module osc_ctrl_test;
  import osc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, rdat, q;
  logic ack, two_spd = 1'b0, fail_in = 1'b0, wake = 1'b0, wait_in = 1'b0;
  logic [2:0] init_src = OSC_PRI;
  logic [1:0] mon_fuses = 2'h0;
  logic [5:0] ready = 6'h3f;
  logic [2:0] src_out, div_out;
  logic dream_out, sec_out, sleep_out, idle_out, nmi_out;
  int fails = 0, cmp_count = 0, wn;
  // short settle count keeps the switch tests brief
  osc_ctrl #(.SETTLE(8)) DUT (.REF_CLK_IN(clk), .RESET_IN(rst), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .INITIAL_SOURCE_FUSES_IN(init_src),
    .TWO_SPEED_FUSE_IN(two_spd), .SWITCH_MONITOR_FUSES_IN(mon_fuses),
    .FAIL_SAFE_MONITOR_IN(fail_in), .WAKE_IN(wake), .WAIT_IN(wait_in),
    .SOURCE_READY_IN(ready), .SYSTEM_CLOCK_SOURCE_OUT(src_out), .FAST_RC_DIVIDER_OUT(div_out),
    .DREAM_MODE_OUT(dream_out), .SECONDARY_OSC_ENABLE_OUT(sec_out), .SLEEP_OUT(sleep_out),
    .IDLE_OUT(idle_out), .NMI_OUT(nmi_out));
  // 25 mhz reference clock
  always #20 clk = ~clk;
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // classic cycle: held until ack is sampled high, data taken at that edge
  task automatic wb(input logic [15:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hf; wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      fails++;
      $display("unexpected no ack at %h", a);
      end_sim();
    end
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  // control writes always go behind the two-key unlock
  task automatic ctl_write(input logic [31:0] d);
    wb(`OSC_OFF_UNLOCK, 1'b1, `OSC_KEY1);
    wb(`OSC_OFF_UNLOCK, 1'b1, `OSC_KEY2);
    wb(`OSC_OFF_CONTROL, 1'b1, d);
  endtask
  task automatic ctl_read();
    wb(`OSC_OFF_CONTROL, 1'b0, 32'h0000_0000);
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
  endtask
  // control word: divider, bits 23..16, new source, bits 7..0
  function automatic logic [31:0] cw(input logic [2:0] dv, input logic [7:0] hi,
    input logic [2:0] ns, input logic [7:0] lo);
    return {5'h00, dv, hi, 5'h00, ns, lo};
  endfunction
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [2:0] codes [6];
    codes = '{OSC_PLL, OSC_PRI, OSC_SEC, OSC_LOW_POWER_INTERNAL_RC, OSC_BACKUP_INTERNAL_RC, OSC_FRC};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    ctl_read();
    `CHK("new_source", OSC_PRI, q[10:8])
    `CHK("switch_request", 1'b0, q[0])
    `CHK("current_source", OSC_PRI, q[14:12])
    `CHK("reset divider", 3'h0, q[26:24])
    `CHK("reset dream", 1'b0, q[23])
    `CHK("reset fail flag", 1'b0, q[3])
    wb(16'h1234, 1'b0, 32'h0);
    `CHK("unmapped read", 32'h0000_0000, q)
    wb(`OSC_OFF_READY, 1'b0, 32'h0);
    `CHK("ready status", 32'h0000_00b5, q & 32'h0000_00b5)
    // write with no unlock must leave everything alone
    wb(`OSC_OFF_CONTROL, 1'b1, cw(3'h7, 8'h80, OSC_PRI, 8'h02));
    ctl_read();
    `CHK("locked out divider", 3'h0, q[26:24])
    `CHK("locked out dream", 1'b0, dream_out)
    for (int i = 0; i < 8; i++) begin
      ctl_write(cw(3'(i), i[0] ? 8'h80 : 8'h00, OSC_PRI, i[1] ? 8'h02 : 8'h00));
      ctl_read();
      `CHK("divider field", 3'(i), q[26:24])
      `CHK("divider out", 3'(i), div_out)
      `CHK("dream out", i[0], dream_out)
      `CHK("secondary out", i[1], sec_out)
    end
    // first switch waits on a target that is not yet ready
    ready <= 6'h3d;
    ctl_write(cw(3'h0, 8'h00, OSC_PLL, 8'h01));
    repeat (20) @(posedge clk);
    ctl_read();
    `CHK("held source", OSC_PRI, src_out)
    `CHK("pending switch", 1'b1, q[0])
    ready <= 6'h3f;
    for (int i = 0; i < 6; i++) begin
      if (i > 0) ctl_write(cw(3'h0, 8'h00, codes[i], 8'h01));
      `WAIT_FOR(src_out === codes[i])
      ctl_read();
      `CHK("current field", codes[i], q[14:12])
      `CHK("switch cleared", 1'b0, q[0])
    end
    // sleep with two-speed wake, then idle with direct wake
    ctl_write(cw(3'h0, 8'h20, OSC_PLL, 8'h11));
    `WAIT_FOR(src_out === OSC_PLL)
    wait_in <= 1'b1;
    `WAIT_FOR(sleep_out === 1'b1)
    wait_in <= 1'b0;
    `CHK("idle in sleep", 1'b0, idle_out)
    ready <= 6'h3d;
    wake <= 1'b1;
    `WAIT_FOR(sleep_out === 1'b0)
    wake <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("wake source", OSC_FRC, src_out)
    ready <= 6'h3f;
    `WAIT_FOR(src_out === OSC_PLL)
    ctl_write(cw(3'h0, 8'h00, OSC_PLL, 8'h00));
    wait_in <= 1'b1;
    `WAIT_FOR(idle_out === 1'b1)
    wait_in <= 1'b0;
    `CHK("sleep in idle", 1'b0, sleep_out)
    wake <= 1'b1;
    `WAIT_FOR(idle_out === 1'b0)
    wake <= 1'b0;
    `CHK("direct wake", OSC_PLL, src_out)
    // clock failure with full monitoring
    mon_fuses <= 2'h3;
    fail_in <= 1'b1;
    `WAIT_FOR(nmi_out === 1'b1)
    `WAIT_FOR(src_out === OSC_FRC)
    fail_in <= 1'b0;
    ctl_read();
    `CHK("fail flag", 1'b1, q[3])
    wb(`OSC_OFF_NMI, 1'b0, 32'h0);
    `CHK("nmi copy set", 1'b1, q[`OSC_NMI_CF_BIT])
    mon_fuses <= 2'h1;
    ctl_write(cw(3'h0, 8'h00, OSC_PLL, 8'h09));
    `WAIT_FOR(src_out === OSC_PLL)
    wb(`OSC_OFF_NMI, 1'b0, 32'h0);
    `CHK("nmi copy cleared", 1'b0, q[`OSC_NMI_CF_BIT])
    ctl_read();
    `CHK("flag kept", 1'b1, q[3])
    ctl_write(cw(3'h0, 8'h00, OSC_PLL, 8'h00));
    ctl_read();
    `CHK("flag cleared", 1'b0, q[3])
    `CHK("nmi released", 1'b0, nmi_out)
    wb(`OSC_OFF_NMI, 1'b1, 32'h0002_0000);
    `CHK("copy nmi", 1'b1, nmi_out)
    `CHK("no forced switch", OSC_PLL, src_out)
    wb(`OSC_OFF_NMI, 1'b1, 32'h0000_0000);
    `CHK("copy nmi off", 1'b0, nmi_out)
    // lock is ignored while switching is enabled, binding once disabled
    mon_fuses <= 2'h0;
    ctl_write(cw(3'h5, 8'h00, OSC_PLL, 8'h80));
    ctl_write(cw(3'h3, 8'h00, OSC_PLL, 8'h80));
    `CHK("unlocked divider", 3'h3, div_out)
    wb(`OSC_OFF_SLEW, 1'b1, `OSC_SLEW_MASK);
    wb(`OSC_OFF_SLEW, 1'b0, 32'h0);
    `CHK("slew written", `OSC_SLEW_MASK, q)
    mon_fuses <= 2'h2;
    ctl_write(cw(3'h6, 8'h80, OSC_PRI, 8'h13));
    ctl_read();
    `CHK("frozen divider", 3'h3, q[26:24])
    `CHK("frozen source", OSC_PLL, q[10:8])
    `CHK("frozen switch", 8'h80, q[7:0] & 8'h93)
    `CHK("dream still open", 1'b1, dream_out)
    wb(`OSC_OFF_SLEW, 1'b1, `OSC_SLEW_RESET);
    wb(`OSC_OFF_SLEW, 1'b0, 32'h0);
    `CHK("frozen slew", `OSC_SLEW_MASK, q)
    // second reset releases the lock and runs two-speed start-up
    two_spd <= 1'b1;
    do_reset();
    ctl_read();
    `CHK("two-speed request", 1'b1, q[0])
    `CHK("lock released", 1'b0, q[7])
    `CHK("new source again", OSC_PRI, q[10:8])
    `CHK("boot source", OSC_FRC, q[14:12])
    `WAIT_FOR(src_out === OSC_PRI)
    ctl_read();
    `CHK("start-up done", 1'b0, q[0])
    end_sim();
  end
endmodule
`default_nettype wire
